// [bgc_regs.sv]
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "bgc_defs.svh"
module bgc_regs #(
  parameter int HOLD_CYC = `BGC_HOLD_CYC
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic        i_falling_slew_force_en,
  input  wire logic        i_ramp_down_active,
  input  wire logic        i_target_reached,
  input  wire logic        i_neg_transient_event,
  input  wire logic        i_min_on_time_pulse,
  output logic      [2:0]  o_shutdown_slew_sel,
  output logic      [2:0]  o_softstart_slew_sel,
  output logic      [2:0]  o_rampdown_slew_sel,
  output logic      [2:0]  o_rampup_slew_sel,
  output logic      [7:0]  o_active_slew_rate,
  output logic             o_peak_current_limit,
  output logic             o_valley_current_limit,
  output logic             o_negative_current_limit,
  output logic             o_adaptive_zero_cross_en,
  output logic             o_share_range_wide,
  output logic             o_phase_share_en,
  output logic             o_body_brake_en,
  output logic             o_pos_transient_boost_en,
  output logic             o_neg_transient_boost_en,
  output logic             o_neg_transient_masked,
  output logic             o_forced_pwm
);
  logic [7:0]  slew_a;
  logic [7:0]  slew_b;
  logic [7:0]  prot;
  logic [9:0]  word_idx;
  logic        acc;
  logic        wr_a;
  logic        wr_b;
  logic        wr_p;
  logic        next_pready;
  logic [31:0] next_prdata;
  logic        next_pslverr;

  // reads decode on the setup beat and answer one cycle later; write strobes fire in the access beat once pready is high
  assign word_idx = paddr[11:2];
  assign acc      = psel & penable & pready;
  assign wr_a     = acc & pwrite & pstrb[0] & (word_idx == {2'b00, `BGC_IDX_SLEW_A});
  assign wr_b     = acc & pwrite & pstrb[0] & (word_idx == {2'b00, `BGC_IDX_SLEW_B});
  assign wr_p     = acc & pwrite & pstrb[0] & (word_idx == {2'b00, `BGC_IDX_PROT});

  // reserved bits 7 and 3 are masked off inside the store
  bgc_cfg_reg #(.RST(`BGC_RST_SLEW_A), .MASK(`BGC_SLEW_MASK)) u_slew_a (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_we       (wr_a),
    .i_wdata    (pwdata[7:0]),
    .o_q        (slew_a)
  );
  bgc_cfg_reg #(.RST(`BGC_RST_SLEW_B), .MASK(`BGC_SLEW_MASK)) u_slew_b (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_we       (wr_b),
    .i_wdata    (pwdata[7:0]),
    .o_q        (slew_b)
  );
  bgc_cfg_reg #(.RST(`BGC_RST_PROT), .MASK(8'hff)) u_prot (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_we       (wr_p),
    .i_wdata    (pwdata[7:0]),
    .o_q        (prot)
  );

  // apb answer: pready rises at the end of setup, so no wait state; unmapped reads give zero and no error
  always_comb begin
    next_pready  = 1'b0;
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (psel & ~penable) begin
      next_pready = 1'b1;
      next_prdata = 32'h0000_0000;
      if (pwrite) begin
        next_prdata = prdata;
      end else if (word_idx == {2'b00, `BGC_IDX_SLEW_A}) begin
        next_prdata = {24'h00_0000, slew_a};
      end else if (word_idx == {2'b00, `BGC_IDX_SLEW_B}) begin
        next_prdata = {24'h00_0000, slew_b};
      end else if (word_idx == {2'b00, `BGC_IDX_PROT}) begin
        next_prdata = {24'h00_0000, prot};
      end else begin
        next_prdata = 32'h0000_0000;
      end
    end else if (psel & penable & ~pready) begin
      next_pready = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= next_pready;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // synchronise the analog-side inputs
  logic [4:0] sync1;
  logic [4:0] sync2;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else begin
      sync1 <= {i_falling_slew_force_en, i_ramp_down_active, i_target_reached,
                i_neg_transient_event, i_min_on_time_pulse};
      sync2 <= sync1;
    end
  end
  logic fs_en;
  logic rd_act;
  logic tgt;
  logic nte;
  logic mot;
  assign fs_en  = sync2[4];
  assign rd_act = sync2[3];
  assign tgt    = sync2[2];
  assign nte    = sync2[1];
  assign mot    = sync2[0];

  // edge of the min on-time pulse counts mask clocks
  logic mot_d;
  logic nte_d;
  logic [3:0] mask_cnt;
  logic [3:0] next_mask_cnt;
  logic [3:0] mask_len;
  assign mask_len = prot[`BGC_BIT_NMASK] ? `BGC_MASK_LONG : `BGC_MASK_SHORT;
  always_comb begin
    next_mask_cnt = mask_cnt;
    if (nte & ~nte_d & prot[`BGC_BIT_NEG_TRANSIENT_RESPONSE]) begin
      next_mask_cnt = mask_len;
    end else if (mot & ~mot_d & (mask_cnt != 4'h0)) begin
      next_mask_cnt = mask_cnt - 4'h1;
    end
  end

  // forced-pwm sequencer; once in hold the timer runs out whatever the target does
  localparam logic [31:0] HOLD_W = HOLD_CYC;
  bgc_pkg::bgc_fall_t fstate;
  bgc_pkg::bgc_fall_t next_fstate;
  logic [31:0] hold_cnt;
  logic [31:0] next_hold_cnt;
  always_comb begin
    next_fstate   = fstate;
    next_hold_cnt = hold_cnt;
    case (fstate)
      bgc_pkg::BGC_IDLE: begin
        if (fs_en & rd_act) begin
          next_fstate = bgc_pkg::BGC_FALL;
        end
      end
      bgc_pkg::BGC_FALL: begin
        if (tgt) begin
          next_fstate   = bgc_pkg::BGC_HOLD;
          next_hold_cnt = HOLD_W - 32'h1;
        end else if (~fs_en) begin
          next_fstate = bgc_pkg::BGC_IDLE;
        end
      end
      bgc_pkg::BGC_HOLD: begin
        if (hold_cnt == 32'h0) begin
          next_fstate = bgc_pkg::BGC_IDLE;
        end else begin
          next_hold_cnt = hold_cnt - 32'h1;
        end
      end
      default: begin
        next_fstate = bgc_pkg::BGC_IDLE;
      end
    endcase
  end

  // derived control outputs, all registered
  logic [2:0] rate_code;
  always_comb begin
    rate_code = slew_b[6:4];
    if (fstate == bgc_pkg::BGC_IDLE) begin
      rate_code = slew_b[2:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      mot_d                    <= 1'b0;
      nte_d                    <= 1'b0;
      mask_cnt                 <= 4'h0;
      fstate                   <= bgc_pkg::BGC_IDLE;
      hold_cnt                 <= 32'h0;
      o_shutdown_slew_sel      <= 3'h2;
      o_softstart_slew_sel     <= 3'h4;
      o_rampdown_slew_sel      <= 3'h2;
      o_rampup_slew_sel        <= 3'h4;
      o_active_slew_rate       <= 8'h00;
      o_peak_current_limit     <= 1'b1;
      o_valley_current_limit   <= 1'b1;
      o_negative_current_limit <= 1'b1;
      o_adaptive_zero_cross_en <= 1'b1;
      o_share_range_wide       <= 1'b0;
      o_phase_share_en         <= 1'b1;
      o_body_brake_en          <= 1'b1;
      o_pos_transient_boost_en <= 1'b1;
      o_neg_transient_boost_en <= 1'b1;
      o_neg_transient_masked   <= 1'b0;
      o_forced_pwm             <= 1'b0;
    end else begin
      mot_d                    <= mot;
      nte_d                    <= nte;
      mask_cnt                 <= next_mask_cnt;
      fstate                   <= next_fstate;
      hold_cnt                 <= next_hold_cnt;
      o_shutdown_slew_sel      <= slew_a[6:4];
      o_softstart_slew_sel     <= slew_a[2:0];
      o_rampdown_slew_sel      <= slew_b[6:4];
      o_rampup_slew_sel        <= slew_b[2:0];
      o_active_slew_rate       <= rate_x4(rate_code);
      o_peak_current_limit     <= ~prot[`BGC_BIT_ILIM_OFF];
      o_valley_current_limit   <= ~prot[`BGC_BIT_ILIM_OFF];
      o_negative_current_limit <= ~prot[`BGC_BIT_ILIM_OFF];
      o_adaptive_zero_cross_en <= prot[`BGC_BIT_AZX];
      o_share_range_wide       <= prot[`BGC_BIT_SHR_WIDE];
      o_phase_share_en         <= prot[`BGC_BIT_SHR_EN];
      o_body_brake_en          <= prot[`BGC_BIT_BRAKE] & prot[`BGC_BIT_POS_TRANSIENT_RESPONSE];
      o_pos_transient_boost_en <= prot[`BGC_BIT_POS_TRANSIENT_RESPONSE];
      o_neg_transient_boost_en <= prot[`BGC_BIT_NEG_TRANSIENT_RESPONSE];
      o_neg_transient_masked   <= (next_mask_cnt != 4'h0);
      o_forced_pwm             <= (next_fstate != bgc_pkg::BGC_IDLE);
    end
  end

  // slew rate in quarter mV/us steps; codes 6 and 7 share the top rate
  function automatic logic [7:0] rate_x4(input logic [2:0] code);
    logic [7:0] r;
    r = 8'hf0;
    case (code)
      3'h0: r = 8'h05;
      3'h1: r = 8'h0a;
      3'h2: r = 8'h14;
      3'h3: r = 8'h28;
      3'h4: r = 8'h50;
      3'h5: r = 8'ha0;
      default: r = 8'hf0;
    endcase
    return r;
  endfunction

  // checks
  slew_reserved_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (slew_a[7] == 1'b0) && (slew_a[3] == 1'b0) && (slew_b[7] == 1'b0) && (slew_b[3] == 1'b0))
    else $error("reserved slew bit set");
  shutdown_sel_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    wr_a |=> ##1 (o_shutdown_slew_sel == $past(pwdata[6:4], 2)))
    else $error("shutdown selector not updated");
  softstart_sel_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    wr_a |=> ##1 (o_softstart_slew_sel == $past(pwdata[2:0], 2)))
    else $error("softstart selector not updated");
  rampdown_sel_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    wr_b |=> ##1 (o_rampdown_slew_sel == $past(pwdata[6:4], 2)))
    else $error("rampdown selector not updated");
  rampup_sel_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    wr_b |=> ##1 (o_rampup_slew_sel == $past(pwdata[2:0], 2)))
    else $error("rampup selector not updated");
  limit_off_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $past(prot[7]) |-> !o_peak_current_limit && !o_valley_current_limit && !o_negative_current_limit)
    else $error("current limit not disabled");
  prot_flags_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    {o_adaptive_zero_cross_en, o_share_range_wide, o_phase_share_en, o_pos_transient_boost_en,
     o_neg_transient_boost_en} == $past({prot[6], prot[5], prot[4], prot[1], prot[0]}))
    else $error("protection flag mismatch");
  brake_gate_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_body_brake_en |-> $past(prot[3]))
    else $error("body brake without enable");
  mask_load_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (nte && !nte_d && prot[`BGC_BIT_NEG_TRANSIENT_RESPONSE]) |=> (mask_cnt == $past(mask_len)))
    else $error("mask count load wrong");
  reserved_rd_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (psel && !penable && !pwrite && (word_idx >= {2'b00, `BGC_IDX_RSVD_LO})) |=> (prdata == 32'h0))
    else $error("reserved index read nonzero");
  hold_time_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (fstate == bgc_pkg::BGC_FALL && next_fstate == bgc_pkg::BGC_HOLD) |=> (hold_cnt == HOLD_W - 32'h1))
    else $error("hold timer load wrong");

  // sequencing, enabled limits and reserved space; a broken counter or decode trips these
  limit_on_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !$past(prot[7]) |-> o_peak_current_limit && o_valley_current_limit && o_negative_current_limit)
    else $error("current limit not enabled");
  brake_on_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    ($past(prot[3]) && $past(prot[1])) |-> o_body_brake_en)
    else $error("body brake not enabled");
  rate_top_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    ($past(rate_code) >= 3'h6) |-> (o_active_slew_rate == 8'hf0))
    else $error("top slew code not at top rate");
  mask_dec_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (mot && !mot_d && (mask_cnt != 4'h0) && !(nte && !nte_d && prot[`BGC_BIT_NEG_TRANSIENT_RESPONSE]))
    |=> (mask_cnt == $past(mask_cnt) - 4'h1))
    else $error("mask count not stepped");
  mask_out_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_neg_transient_masked == (mask_cnt != 4'h0))
    else $error("mask flag disagrees with count");
  fall_enter_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (fstate == bgc_pkg::BGC_IDLE && fs_en && rd_act) |=> (fstate == bgc_pkg::BGC_FALL && o_forced_pwm))
    else $error("forced fall not entered");
  fpwm_idle_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (fstate == bgc_pkg::BGC_IDLE && !(fs_en && rd_act)) |=> !o_forced_pwm)
    else $error("forced pwm while idle");
  hold_run_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (fstate == bgc_pkg::BGC_HOLD && hold_cnt != 32'h0) |=> (fstate == bgc_pkg::BGC_HOLD && o_forced_pwm))
    else $error("hold ended early");
  rsvd_nowrite_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (acc && pwrite && (word_idx >= {2'b00, `BGC_IDX_RSVD_LO}))
    |=> ($stable(slew_a) && $stable(slew_b) && $stable(prot)))
    else $error("reserved write changed the bank");
endmodule

// [bgc_defs.svh]
`ifndef BGC_DEFS_SVH
`define BGC_DEFS_SVH
// register indices; byte address is four times the index
`define BGC_IDX_SLEW_A      8'h33
`define BGC_IDX_SLEW_B      8'h34
`define BGC_IDX_PROT        8'h35
`define BGC_IDX_RSVD_LO     8'h36
`define BGC_IDX_RSVD_HI     8'hff
// reset values
`define BGC_RST_SLEW_A      8'h24
`define BGC_RST_SLEW_B      8'h24
`define BGC_RST_PROT        8'h5f
`define BGC_SLEW_MASK       8'h77
// field positions
`define BGC_HI_SEL_LSB      4
`define BGC_LO_SEL_LSB      0
`define BGC_BIT_ILIM_OFF    7
`define BGC_BIT_AZX         6
`define BGC_BIT_SHR_WIDE    5
`define BGC_BIT_SHR_EN      4
`define BGC_BIT_BRAKE       3
`define BGC_BIT_NMASK       2
`define BGC_BIT_POS_TRANSIENT_RESPONSE        1
`define BGC_BIT_NEG_TRANSIENT_RESPONSE        0
// mask lengths in minimum on-time clocks
`define BGC_MASK_SHORT      4'h2
`define BGC_MASK_LONG       4'h8
// forced pwm hold after target
`define BGC_HOLD_US         50
`define BGC_CLK_MHZ         40
`define BGC_HOLD_CYC        ((`BGC_HOLD_US) * (`BGC_CLK_MHZ))
`endif

// [bgc_pkg.sv]
package bgc_pkg;
  typedef enum logic [1:0] {BGC_IDLE, BGC_FALL, BGC_HOLD} bgc_fall_t;
endpackage

// [bgc_cfg_reg.sv]
`timescale 1ns/1ps
`include "bgc_defs.svh"
// one configuration byte with reset value and writable mask
module bgc_cfg_reg #(
  parameter logic [7:0] RST  = 8'h00,
  parameter logic [7:0] MASK = 8'hff
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  input  wire logic       i_we,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_q
);
  logic [7:0] next_q;

  // masked bits never take write data, so they stay zero
  always_comb begin
    next_q = o_q;
    if (i_we) begin
      next_q = i_wdata & MASK;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_q <= RST;
    end else begin
      o_q <= next_q;
    end
  end
endmodule

// [buck_global_config_regs_bench.sv]
`timescale 1ns/1ps
`include "bgc_defs.svh"
module buck_global_config_regs_bench;
  logic        i_core_clk;
  logic        i_reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        i_falling_slew_force_en;
  logic        i_ramp_down_active;
  logic        i_target_reached;
  logic        i_neg_transient_event;
  logic        i_min_on_time_pulse;
  logic [2:0]  o_shutdown_slew_sel;
  logic [2:0]  o_softstart_slew_sel;
  logic [2:0]  o_rampdown_slew_sel;
  logic [2:0]  o_rampup_slew_sel;
  logic [7:0]  o_active_slew_rate;
  logic        o_peak_current_limit;
  logic        o_valley_current_limit;
  logic        o_negative_current_limit;
  logic        o_adaptive_zero_cross_en;
  logic        o_share_range_wide;
  logic        o_phase_share_en;
  logic        o_body_brake_en;
  logic        o_pos_transient_boost_en;
  logic        o_neg_transient_boost_en;
  logic        o_neg_transient_masked;
  logic        o_forced_pwm;
  logic [11:0] sels;
  logic [11:0] flags;
  logic [31:0] rd;
  logic        slverr;
  int          error_cnt;
  int          num_checks;
  // rate in quarter mV/us units, codes 6 and 7 both top out
  logic [7:0]  rate_tbl [8] = '{8'h05, 8'h0a, 8'h14, 8'h28, 8'h50, 8'ha0, 8'hf0, 8'hf0};

  assign sels  = {o_shutdown_slew_sel, o_softstart_slew_sel, o_rampdown_slew_sel, o_rampup_slew_sel};
  assign flags = {1'b0, o_peak_current_limit, o_valley_current_limit, o_negative_current_limit,
                  o_adaptive_zero_cross_en, o_share_range_wide, o_phase_share_en, o_body_brake_en,
                  o_pos_transient_boost_en, o_neg_transient_boost_en, o_neg_transient_masked, o_forced_pwm};

  // short hold so the forced pwm window fits in a quick run
  bgc_regs #(.HOLD_CYC(20)) dut_u (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .i_falling_slew_force_en(i_falling_slew_force_en), .i_ramp_down_active(i_ramp_down_active),
    .i_target_reached(i_target_reached), .i_neg_transient_event(i_neg_transient_event),
    .i_min_on_time_pulse(i_min_on_time_pulse), .o_shutdown_slew_sel(o_shutdown_slew_sel),
    .o_softstart_slew_sel(o_softstart_slew_sel), .o_rampdown_slew_sel(o_rampdown_slew_sel),
    .o_rampup_slew_sel(o_rampup_slew_sel), .o_active_slew_rate(o_active_slew_rate),
    .o_peak_current_limit(o_peak_current_limit), .o_valley_current_limit(o_valley_current_limit),
    .o_negative_current_limit(o_negative_current_limit), .o_adaptive_zero_cross_en(o_adaptive_zero_cross_en),
    .o_share_range_wide(o_share_range_wide), .o_phase_share_en(o_phase_share_en),
    .o_body_brake_en(o_body_brake_en), .o_pos_transient_boost_en(o_pos_transient_boost_en),
    .o_neg_transient_boost_en(o_neg_transient_boost_en), .o_neg_transient_masked(o_neg_transient_masked),
    .o_forced_pwm(o_forced_pwm));

  // free running core clock
  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end

  task automatic end_of_test;
    if (error_cnt == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected read at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected output at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  // one transfer plus an idle edge, so back-to-back calls never drive psel twice in a step
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] st);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h0, wd};
    pstrb   <= st;
    @(posedge i_core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      end_of_test();
    end
    rd = prdata;
    slverr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge i_core_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 4'h1);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00, 4'h0);
    chk_reg(rd, {24'h0, exp});
  endtask

  // bounded wait on forced pwm (sel 1) or the mask flag (sel 0)
  task automatic wait_bit(input logic sel, input logic lvl, input int lim);
    int n;
    n = 0;
    while (((sel ? o_forced_pwm : o_neg_transient_masked) !== lvl) && n < lim) begin
      @(posedge i_core_clk);
      n++;
    end
    if ((sel ? o_forced_pwm : o_neg_transient_masked) !== lvl) begin
      error_cnt++;
      end_of_test();
    end
  endtask

  function automatic logic [11:0] exp_flags(input logic [7:0] p);
    return {1'b0, {3{~p[7]}}, p[6], p[5], p[4], p[3] & p[1], p[1], p[0], 2'b00};
  endfunction

  task automatic t_reset;
    rd_chk(`BGC_IDX_SLEW_A, 8'h24);
    rd_chk(`BGC_IDX_SLEW_B, 8'h24);
    rd_chk(`BGC_IDX_PROT, 8'h5f);
    chk_out(sels, {3'h2, 3'h4, 3'h2, 3'h4});
    chk_out(flags, exp_flags(8'h5f));
    chk_out({4'h0, o_active_slew_rate}, 12'h050);
  endtask

  // every rate code in every selector, reserved bits written high
  task automatic t_slew;
    logic [2:0] c;
    for (int k = 0; k < 8; k++) begin
      c = k[2:0];
      wr(`BGC_IDX_SLEW_A, {1'b1, c, 1'b1, c});
      wr(`BGC_IDX_SLEW_B, {1'b1, c, 1'b1, c});
      rd_chk(`BGC_IDX_SLEW_A, {1'b0, c, 1'b0, c});
      rd_chk(`BGC_IDX_SLEW_B, {1'b0, c, 1'b0, c});
      chk_out(sels, {c, c, c, c});
      chk_out({4'h0, o_active_slew_rate}, {4'h0, rate_tbl[k]});
    end
  endtask

  task automatic t_prot;
    logic [7:0] pv [11] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h0a, 8'h04, 8'h02, 8'h01, 8'h00, 8'hff};
    for (int k = 0; k < 11; k++) begin
      wr(`BGC_IDX_PROT, pv[k]);
      rd_chk(`BGC_IDX_PROT, pv[k]);
      chk_out(flags, exp_flags(pv[k]));
    end
  endtask

  // reserved space and a write with lane 0 disabled leave the bank alone
  task automatic t_rsvd;
    logic [7:0] ix [3] = '{8'h36, 8'h80, 8'hff};
    wr(`BGC_IDX_SLEW_A, 8'h24);
    for (int k = 0; k < 3; k++) begin
      wr(ix[k], 8'ha5);
      rd_chk(ix[k], 8'h00);
      chk_reg({31'h0, slverr}, 32'h0);
    end
    apb(1'b1, `BGC_IDX_SLEW_A, 8'h55, 4'h0);
    rd_chk(`BGC_IDX_SLEW_A, 8'h24);
    rd_chk(`BGC_IDX_PROT, 8'hff);
  endtask

  task automatic t_mask(input logic len, input int n);
    wr(`BGC_IDX_PROT, 8'h5b | {5'h0, len, 2'b00});
    i_neg_transient_event <= 1'b1;
    tick(4);
    i_neg_transient_event <= 1'b0;
    wait_bit(1'b0, 1'b1, 10);
    for (int k = 1; k <= n; k++) begin
      i_min_on_time_pulse <= 1'b1;
      tick(3);
      i_min_on_time_pulse <= 1'b0;
      tick(4);
      chk_out({11'h0, o_neg_transient_masked}, {11'h0, k < n});
    end
  endtask

  task automatic t_mask_off;
    wr(`BGC_IDX_PROT, 8'h5e);
    i_neg_transient_event <= 1'b1;
    tick(4);
    i_neg_transient_event <= 1'b0;
    tick(6);
    chk_out({11'h0, o_neg_transient_masked}, 12'h000);
  endtask

  // forced pwm needs the force enable; hold window after target stays bounded
  task automatic t_fpwm;
    wr(`BGC_IDX_SLEW_B, 8'h12);
    i_ramp_down_active <= 1'b1;
    tick(8);
    chk_out({11'h0, o_forced_pwm}, 12'h000);
    i_falling_slew_force_en <= 1'b1;
    wait_bit(1'b1, 1'b1, 10);
    tick(1);
    chk_out({4'h0, o_active_slew_rate}, 12'h00a);
    i_target_reached   <= 1'b1;
    i_ramp_down_active <= 1'b0;
    tick(20);
    chk_out({11'h0, o_forced_pwm}, 12'h001);
    wait_bit(1'b1, 1'b0, 6);
    tick(2);
    chk_out({4'h0, o_active_slew_rate}, 12'h014);
  endtask

  initial begin
    error_cnt = 0;
    num_checks = 0;
    i_reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    i_falling_slew_force_en = 1'b0;
    i_ramp_down_active = 1'b0;
    i_target_reached = 1'b0;
    i_neg_transient_event = 1'b0;
    i_min_on_time_pulse = 1'b0;
    tick(5);
    i_reset <= 1'b0;
    tick(1);
    t_reset();
    t_slew();
    t_prot();
    t_rsvd();
    t_mask(1'b0, 2);
    t_mask(1'b1, 8);
    t_mask_off();
    t_fpwm();
    end_of_test();
  end
endmodule
